// File: hdl/pmv_pkg.sv
`default_nettype none
package pmv_pkg;
    localparam int          PMV_PC_W        = 21;
    localparam int          PMV_SP_W        = 5;
    localparam int          PMV_WORD_W      = 16;
    localparam logic [20:0] PMV_SPACE_TOP   = 21'h1fffff;
    localparam logic [20:0] PMV_FLASH_SMALL = 21'h00c000;
    localparam logic [20:0] PMV_FLASH_LARGE = 21'h010000;
    localparam logic [20:0] PMV_RESET_VEC   = 21'h000000;
    localparam logic [20:0] PMV_HI_VEC      = 21'h000008;
    localparam logic [20:0] PMV_LO_VEC      = 21'h000018;
    localparam logic [20:0] PMV_PC_STEP     = 21'h000002;
    localparam logic [4:0]  PMV_SP_RESET    = 5'h00;
    localparam logic [4:0]  PMV_STACK_DEPTH = 5'h1f;

    typedef struct packed {
        logic        call;
        logic        ret;
        logic        jump;
        logic [20:0] target;
    } pmv_flow_s;

    typedef struct packed {
        logic wake;
        logic high_priority;
        logic high_priority_global_enable;
        logic low_priority_global_enable;
        logic source_flag;
    } pmv_irq_s;
endpackage
`default_nettype wire

// File: hdl/pmv_vectoring.sv
`timescale 1ns/100ps
`default_nettype none
module pmv_vectoring import pmv_pkg::*; #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // core sequencing
    input  wire logic                  advance,
    input  wire pmv_flow_s             flow,
    input  wire pmv_irq_s              irq,
    // program bus to flash
    input  wire logic [PMV_WORD_W-1:0] flash_rdata,
    output logic      [PMV_PC_W-1:0]   fetch_addr_ff,
    output logic      [PMV_WORD_W-1:0] fetch_word_ff,
    // stack and wake state
    output logic      [PMV_PC_W-1:0]   stack_top_ff,
    output logic      [PMV_SP_W-1:0]   return_stack_pointer_ff,
    output logic                       wake_flag_ff,
    output logic                       stack_full_ff
);
    localparam logic [20:0] FLASH_TOP = LARGE_VARIANT ? PMV_FLASH_LARGE
                                                      : PMV_FLASH_SMALL;

    logic [PMV_PC_W-1:0]   pc_ff;
    logic [PMV_PC_W-1:0]   nxt_pc;
    logic [PMV_SP_W-1:0]   nxt_sp;
    logic [PMV_PC_W-1:0]   nxt_top;
    logic [PMV_WORD_W-1:0] nxt_word;
    logic                  nxt_flag;
    logic                  nxt_full;
    logic                  push;
    logic                  take_irq;
    logic [PMV_PC_W-1:0]   seq_pc;
    logic [PMV_PC_W-1:0]   stack_mem_ff [1:31];

    // one instruction word ahead; wraps at the top of the space
    function automatic logic [PMV_PC_W-1:0] step_pc(
        input logic [PMV_PC_W-1:0] pc
    );
        return pc + PMV_PC_STEP;
    endfunction

    // entry only when the priority's own enable is set
    assign take_irq = irq.wake && (irq.high_priority ?
                      irq.high_priority_global_enable :
                      irq.low_priority_global_enable);
    assign seq_pc   = step_pc(pc_ff);
    assign push     = take_irq || (advance && flow.call);

    always_comb begin
        nxt_pc   = pc_ff;
        nxt_sp   = return_stack_pointer_ff;
        nxt_top  = stack_top_ff;
        nxt_flag = wake_flag_ff;
        nxt_full = stack_full_ff;
        // fetch has its own bus; data traffic never stalls it
        nxt_word = (pc_ff < FLASH_TOP) ? flash_rdata : '0;
        // an interrupt wake with source_flag set marks its source, enabled or not
        if (irq.wake && irq.source_flag) begin
            nxt_flag = 1'b1;
        end
        if (take_irq) begin
            nxt_pc = irq.high_priority ? PMV_HI_VEC : PMV_LO_VEC;
        end else if (advance) begin
            if (flow.ret) begin
                nxt_pc = (return_stack_pointer_ff == PMV_SP_RESET) ?
                         PMV_RESET_VEC : stack_top_ff;
                if (return_stack_pointer_ff != PMV_SP_RESET) begin
                    nxt_sp = return_stack_pointer_ff - 5'h01;
                end
            end else if (flow.call || flow.jump) begin
                nxt_pc = {flow.target[20:1], 1'b0};
            end else begin
                nxt_pc = seq_pc;
            end
        end
        // increment first; saturate at 31 so the last entry is kept
        if (push && return_stack_pointer_ff != PMV_STACK_DEPTH) begin
            nxt_sp  = return_stack_pointer_ff + 5'h01;
            nxt_top = take_irq ? pc_ff : seq_pc;
            if (nxt_sp == PMV_STACK_DEPTH) begin
                nxt_full = 1'b1;
            end
        end else if (advance && flow.ret && !take_irq &&
                     return_stack_pointer_ff > 5'h01) begin
            nxt_top = stack_mem_ff[return_stack_pointer_ff - 5'h01];
        end
        if (push && return_stack_pointer_ff == PMV_STACK_DEPTH) begin
            nxt_full = 1'b1;
        end
        nxt_pc[0] = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_ff                   <= PMV_RESET_VEC;
            fetch_addr_ff           <= PMV_RESET_VEC;
            fetch_word_ff           <= '0;
            stack_top_ff            <= '0;
            return_stack_pointer_ff <= PMV_SP_RESET;
            wake_flag_ff            <= 1'b0;
            stack_full_ff           <= 1'b0;
        end else begin
            pc_ff                   <= nxt_pc;
            fetch_addr_ff           <= nxt_pc;
            fetch_word_ff           <= nxt_word;
            stack_top_ff            <= nxt_top;
            return_stack_pointer_ff <= nxt_sp;
            wake_flag_ff            <= nxt_flag;
            stack_full_ff           <= nxt_full;
        end
    end

    // stack ram has no reset; slot 0 is a pointer value only
    always_ff @(posedge clk) begin
        if (push && return_stack_pointer_ff != PMV_STACK_DEPTH) begin
            stack_mem_ff[nxt_sp] <= nxt_top;
        end
    end

    vector_hi_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        take_irq && irq.high_priority |=> pc_ff == PMV_HI_VEC)
        else $error("high priority vector not taken");

    vector_lo_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        take_irq && !irq.high_priority |=> pc_ff == PMV_LO_VEC)
        else $error("low priority vector not taken");

    irq_refused_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        irq.wake && !take_irq && !advance |=>
        $stable(pc_ff) && $stable(return_stack_pointer_ff))
        else $error("disabled interrupt was taken");

    push_pc_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        take_irq && return_stack_pointer_ff != PMV_STACK_DEPTH |=>
        stack_top_ff == $past(pc_ff) &&
        return_stack_pointer_ff == $past(return_stack_pointer_ff) + 5'h01)
        else $error("interrupt push wrong");

    call_push_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        advance && flow.call && !take_irq &&
        return_stack_pointer_ff != PMV_STACK_DEPTH |=>
        stack_top_ff == step_pc($past(pc_ff)))
        else $error("call push wrong");

    call_target_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        advance && flow.call && !flow.ret && !take_irq |=>
        pc_ff == {$past(flow.target[20:1]), 1'b0})
        else $error("call target wrong");

    ret_pop_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        advance && flow.ret && !flow.call && !take_irq &&
        return_stack_pointer_ff != PMV_SP_RESET |=>
        pc_ff == $past(stack_top_ff) &&
        return_stack_pointer_ff == $past(return_stack_pointer_ff) - 5'h01)
        else $error("return pop wrong");

    ret_empty_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        advance && flow.ret && !flow.call && !take_irq &&
        return_stack_pointer_ff == PMV_SP_RESET |=>
        pc_ff == PMV_RESET_VEC && return_stack_pointer_ff == PMV_SP_RESET)
        else $error("empty stack return wrong");

    pc_align_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        pc_ff[0] == 1'b0)
        else $error("counter misaligned");

    seq_step_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        advance && !take_irq && !flow.call && !flow.ret && !flow.jump
        |=> pc_ff == step_pc($past(pc_ff)))
        else $error("sequential step wrong");

    jump_target_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        advance && flow.jump && !flow.call && !flow.ret && !take_irq |=>
        pc_ff == {$past(flow.target[20:1]), 1'b0})
        else $error("jump target wrong");

    zero_fill_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        pc_ff >= FLASH_TOP |=> fetch_word_ff == '0)
        else $error("unimplemented fetch not zero");

    flash_pass_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        pc_ff < FLASH_TOP |=> fetch_word_ff == $past(flash_rdata))
        else $error("flash word not passed");

    sp_limit_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        return_stack_pointer_ff <= PMV_STACK_DEPTH)
        else $error("stack pointer beyond depth");

    full_set_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        push && return_stack_pointer_ff == PMV_STACK_DEPTH - 5'h01 |=>
        stack_full_ff && return_stack_pointer_ff == PMV_STACK_DEPTH)
        else $error("full not set on last push");

    full_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        push && !flow.ret && return_stack_pointer_ff == PMV_STACK_DEPTH |=>
        return_stack_pointer_ff == PMV_STACK_DEPTH && $stable(stack_top_ff))
        else $error("push past full changed the stack");

    full_sticky_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        stack_full_ff |=> stack_full_ff)
        else $error("full flag dropped");

    wake_flag_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        irq.wake && irq.source_flag |=> wake_flag_ff)
        else $error("wake flag not set");

    flag_sticky_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wake_flag_ff |=> wake_flag_ff)
        else $error("wake flag dropped");
endmodule
`default_nettype wire

// File: test/pmv_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module pmv_flash_model import pmv_pkg::*; (
    // program bus
    input  wire logic [PMV_PC_W-1:0]   addr,
    output logic      [PMV_WORD_W-1:0] rdata
);
    // aliases above the top, not forced to zero: zero-fill is the core's job
    assign rdata = addr[16:1] ^ 16'h5a5a;
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import pmv_pkg::*;;
    logic        clk, rst_n, advance, wake_flag_ff, stack_full_ff;
    pmv_flow_s   flow;
    pmv_irq_s    irq;
    logic [15:0] flash_rdata, fetch_word_ff;
    logic [20:0] fetch_addr_ff, stack_top_ff;
    logic [4:0]  sp;
    logic [15:0] sm_rdata, sm_word;
    logic [20:0] sm_addr;
    int          mismatches, samples_checked;
    pmv_vectoring #(.LARGE_VARIANT(1'b1)) u_pmv_vectoring (.clk(clk),
        .rst_n(rst_n), .advance(advance), .flow(flow), .irq(irq),
        .flash_rdata(flash_rdata), .fetch_addr_ff(fetch_addr_ff),
        .fetch_word_ff(fetch_word_ff), .stack_top_ff(stack_top_ff),
        .return_stack_pointer_ff(sp), .wake_flag_ff(wake_flag_ff),
        .stack_full_ff(stack_full_ff));
    pmv_flash_model u_pmv_flash_model (.addr(fetch_addr_ff),
        .rdata(flash_rdata));
    // smaller flash variant, same stimulus as the main one
    pmv_vectoring #(.LARGE_VARIANT(1'b0)) u_pmv_vectoring_small (.clk(clk),
        .rst_n(rst_n), .advance(advance), .flow(flow), .irq(irq),
        .flash_rdata(sm_rdata), .fetch_addr_ff(sm_addr),
        .fetch_word_ff(sm_word), .stack_top_ff(),
        .return_stack_pointer_ff(), .wake_flag_ff(), .stack_full_ff());
    pmv_flash_model u_pmv_flash_model_small (.addr(sm_addr),
        .rdata(sm_rdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic go(input logic a, input pmv_flow_s f, input pmv_irq_s i);
        @(posedge clk);
        advance <= a;
        flow <= f;
        irq <= i;
        @(posedge clk);
        advance <= 1'b0;
        flow <= '0;
        irq <= '0;
        #1;
    endtask
    function automatic pmv_flow_s fl(logic c, logic r, logic [20:0] t);
        return '{call: c, ret: r, jump: !c && !r, target: t};
    endfunction
    function automatic pmv_irq_s ir(logic hp, logic eh, logic el);
        return '{wake: 1'b1, high_priority: hp,
            high_priority_global_enable: eh,
            low_priority_global_enable: el, source_flag: 1'b1};
    endfunction
    task automatic stop_test();
        $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_fetch();
        logic [20:0] p [5] = '{21'h00bffe, PMV_FLASH_SMALL, 21'h00fffe,
            PMV_FLASH_LARGE, 21'h1ffffe};
        logic [20:0] nx;
        logic [15:0] w;
        repeat (3) go(1'b1, '0, '0);
        chk(fetch_addr_ff, 21'h6);
        go(1'b1, fl(1'b0, 1'b0, 21'h000101), '0);
        chk(fetch_addr_ff, 21'h100);
        foreach (p[k]) begin
            go(1'b1, fl(1'b0, 1'b0, p[k]), '0);
            go(1'b1, '0, '0);
            nx = p[k] + PMV_PC_STEP;
            w = p[k][16:1] ^ 16'h5a5a;
            chk(fetch_word_ff, p[k] < PMV_FLASH_LARGE ? w : '0);
            chk(sm_word, p[k] < PMV_FLASH_SMALL ? w : '0);
            chk(fetch_addr_ff, nx);
        end
        $display("test fetch done");
    endtask
    task automatic t_vector();
        go(1'b1, fl(1'b0, 1'b0, 21'h000040), '0);
        go(1'b0, '0, ir(1'b1, 1'b1, 1'b0));
        chk({fetch_addr_ff, sp}, {PMV_HI_VEC, 5'h1});
        chk({stack_top_ff, wake_flag_ff}, {21'h40, 1'b1});
        go(1'b0, '0, ir(1'b0, 1'b0, 1'b1));
        chk({fetch_addr_ff, sp}, {PMV_LO_VEC, 5'h2});
        chk(stack_top_ff, PMV_HI_VEC);
        go(1'b0, '0, ir(1'b1, 1'b0, 1'b1));
        chk({fetch_addr_ff, sp}, {PMV_LO_VEC, 5'h2});
        go(1'b1, fl(1'b1, 1'b0, 21'h000200), '0);
        chk({fetch_addr_ff, sp}, {21'h200, 5'h3});
        chk(stack_top_ff, 21'h1a);
        go(1'b1, fl(1'b0, 1'b1, 21'h0), '0);
        chk({fetch_addr_ff, sp}, {21'h1a, 5'h2});
        chk(stack_top_ff, PMV_HI_VEC);
        $display("test vector done");
    endtask
    task automatic t_full();
        repeat (29) go(1'b1, fl(1'b1, 1'b0, 21'h000300), '0);
        chk({sp, stack_full_ff}, {5'h1f, 1'b1});
        go(1'b1, fl(1'b0, 1'b0, 21'h000500), '0);
        go(1'b1, fl(1'b1, 1'b0, 21'h000300), '0);
        chk({sp, stack_top_ff}, {5'h1f, 21'h302});
        chk(fetch_addr_ff, 21'h300);
        $display("test full done");
    endtask
    task automatic t_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({fetch_addr_ff, sp}, {PMV_RESET_VEC, 5'h0});
        chk({stack_full_ff, wake_flag_ff}, 2'b00);
        go(1'b1, fl(1'b0, 1'b0, 21'h000060), '0);
        go(1'b0, '0, ir(1'b1, 1'b0, 1'b0));
        chk({fetch_addr_ff, sp}, {21'h60, 5'h0});
        chk(wake_flag_ff, 1'b1);
        go(1'b1, fl(1'b0, 1'b1, 21'h0), '0);
        chk({fetch_addr_ff, sp}, {PMV_RESET_VEC, 5'h0});
        $display("test reset done");
    endtask
    initial begin
        {rst_n, advance} = 2'b00;
        flow = '0;
        irq = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({fetch_addr_ff, sp}, {PMV_RESET_VEC, 5'h0});
        t_fetch();
        t_vector();
        t_full();
        t_reset();
        stop_test();
    end
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire
